// ---- rtl/lbk_regs.svh ----
// register map, field positions and reset values of the loopback/status/transmit bank
`ifndef LBK_REGS_SVH
`define LBK_REGS_SVH

// register addresses
`define LBK_ADDR_LOOP 8'h02
`define LBK_ADDR_LOS_A 8'h1F
`define LBK_ADDR_LOS_B 8'h3F
`define LBK_ADDR_CFG_A 8'hC0
`define LBK_ADDR_LVL1_A 8'hC1
`define LBK_ADDR_LVL0_A 8'hC2
`define LBK_ADDR_CFG_B 8'hE0
`define LBK_ADDR_LVL1_B 8'hE1
`define LBK_ADDR_LVL0_B 8'hE2

// reset values
`define LBK_LOOP_RST 8'h00
`define LBK_CFG_RST 8'h20
`define LBK_LVL_RST 8'h40
`define LBK_UNMAPPED 8'h00

// implemented-bit masks, other bits read zero
`define LBK_LOOP_MASK 8'h03
`define LBK_CFG_MASK 8'h37

// field positions
`define LBK_LOOP_CABLE_BIT 0
`define LBK_LOOP_BOARD_BIT 1
`define LBK_CFG_EN_BIT 5
`define LBK_CFG_RATE_BIT 4
`define LBK_CFG_PE_MSB 2
`define LBK_LVL_SRC_BIT 7
`define LBK_LVL_MSB 6

// serial byte framing
`define LBK_BYTE_BITS 4'h8
`define LBK_LAST_BIT 4'h7

`endif

// ---- rtl/lbk_pkg.sv ----
// types shared by the loopback/status/transmit bank
package lbk_pkg;
    typedef logic [7:0] lbk_byte_t;
    typedef logic [2:0] lbk_pe_t;
    typedef logic [6:0] lbk_lvl_t;
    typedef enum {LBK_ST_IDLE, LBK_ST_ADDR, LBK_ST_AACK, LBK_ST_REG, LBK_ST_REG_ACK,
        LBK_ST_WDATA, LBK_ST_WACK, LBK_ST_RDATA, LBK_ST_RACK} lbk_i2c_state_t;
    typedef enum {LBK_R_NONE, LBK_R_LOOP, LBK_R_LOS_A, LBK_R_LOS_B, LBK_R_CFG_A,
        LBK_R_LVL1_A, LBK_R_LVL0_A, LBK_R_CFG_B, LBK_R_LVL1_B, LBK_R_LVL0_B} lbk_reg_t;
endpackage

// ---- rtl/lbk_sync.sv ----
// three-flop input synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module lbk_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // first stage feeds only the second one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per bit: a change counts once it has stood two samples
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                q[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
                q[i] <= s3_r[i];
            end
        end
    end
endmodule // lbk_sync
`default_nettype wire

// ---- rtl/lbk_los_latch.sv ----
// latched no-signal flags for one port
`timescale 1ns/1ps
`default_nettype none
module lbk_los_latch #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] live,
    input wire logic clr_stb,
    input wire logic [N-1:0] clr_data,
    output logic [N-1:0] latched
);
    // a live loss sets the flag even in the clearing cycle; writing 1 leaves it
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                latched[i] <= 1'b0;
            end else if (live[i]) begin
                latched[i] <= 1'b1;
            end else if (clr_stb && !clr_data[i]) begin
                latched[i] <= 1'b0;
            end
        end
    end
endmodule // lbk_los_latch
`default_nettype wire

// ---- rtl/lbk_top.sv ----
// loopback, signal-loss status and transmit configuration bank behind a serial slave
//
// How it works
// - per-port status: latched high nibble, live low
// - live follows loss; latched sticks until zero-write
// - toggle pin drives board-side loopback only
// - board loopback keeps the through path running
// - bit0 cable-side, bit1 board-side loopback
// - in pin mode pin overrides bit 1
// - both bits set stop all through traffic
// - pin modes ignore bits, pin selects board
// - serial modes ignore pin, decode two bits
// - eight settings, pins reach 0/2/4/6
// - written 3-bit field beats the pins
// - port settings shared by all four channels
// - config bit 4 selects high data rate
// - level register 1 bit 7 picks source
// - config: enable, rate, field; resets 0x20
// - two level registers, 7-bit fields, reset 0x40
`include "lbk_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lbk_top #(
    parameter int NUM_CH = 4,
    // slave address value is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h38
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [NUM_CH-1:0] los_live_a,
    input wire logic [NUM_CH-1:0] los_live_b,
    input wire logic loopback_toggle_pin,
    input wire logic [1:0] preemph_toggle_pins_a,
    input wire logic [1:0] preemph_toggle_pins_b,
    input wire logic [1:0] control_mode,
    output logic cable_side_loop_en,
    output logic board_side_loop_en,
    output logic through_path_en,
    output lbk_pkg::lbk_pe_t [1:0] preemph_setting,
    output logic [1:0] data_rate_high,
    output logic [1:0] out_enable,
    output logic [1:0] preemph_source_select,
    output lbk_pkg::lbk_lvl_t [1:0] output_level_field_one,
    output lbk_pkg::lbk_lvl_t [1:0] output_level_field_zero
);
    import lbk_pkg::*;

    // status byte layout is fixed at four channels per port
    if (NUM_CH != 4) begin : g_bad_ch
        $error("lbk_top: NUM_CH must be 4");
    end

    localparam int SW = 2 * NUM_CH + 9;

    logic [SW-1:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic toggle_s;
    logic [1:0] pe_pins_s [2];
    logic [1:0] mode_s;
    logic [NUM_CH-1:0] live_s [2];
    logic [NUM_CH-1:0] latched [2];
    logic scl_prev_r;
    logic sda_prev_r;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    lbk_i2c_state_t state_r;
    logic [3:0] cnt_r;
    lbk_byte_t shift_r;
    lbk_byte_t ptr_r;
    logic rw_r;
    logic nack_r;
    logic wr_stb_r;
    lbk_byte_t rd_byte;
    lbk_reg_t wr_sel;
    lbk_reg_t rd_sel;
    lbk_byte_t loop_r;
    lbk_byte_t cfg_r [2];
    lbk_byte_t lvl1_r [2];
    lbk_byte_t lvl0_r [2];
    logic [1:0] pe_written_r;
    logic serial_mode;
    logic cable_nxt;
    logic board_nxt;

    // register address decode, shared by the write and read sides
    function automatic lbk_reg_t reg_decode(input lbk_byte_t a);
        lbk_reg_t r;
        r = LBK_R_NONE;
        case (a)
            `LBK_ADDR_LOOP: r = LBK_R_LOOP;
            `LBK_ADDR_LOS_A: r = LBK_R_LOS_A;
            `LBK_ADDR_LOS_B: r = LBK_R_LOS_B;
            `LBK_ADDR_CFG_A: r = LBK_R_CFG_A;
            `LBK_ADDR_LVL1_A: r = LBK_R_LVL1_A;
            `LBK_ADDR_LVL0_A: r = LBK_R_LVL0_A;
            `LBK_ADDR_CFG_B: r = LBK_R_CFG_B;
            `LBK_ADDR_LVL1_B: r = LBK_R_LVL1_B;
            `LBK_ADDR_LVL0_B: r = LBK_R_LVL0_B;
            default: r = LBK_R_NONE;
        endcase
        return r;
    endfunction

    // all pins are asynchronous: one shared synchroniser
    lbk_sync #(
        .W(SW)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .raw({scl_in, sda_in, loopback_toggle_pin, preemph_toggle_pins_b,
            preemph_toggle_pins_a, control_mode, los_live_b, los_live_a}),
        .q(sync_q)
    );

    // unpack the synchronised pins
    assign live_s[0] = sync_q[NUM_CH-1:0];
    assign live_s[1] = sync_q[2*NUM_CH-1:NUM_CH];
    assign mode_s = sync_q[2*NUM_CH+1:2*NUM_CH];
    assign pe_pins_s[0] = sync_q[2*NUM_CH+3:2*NUM_CH+2];
    assign pe_pins_s[1] = sync_q[2*NUM_CH+5:2*NUM_CH+4];
    assign toggle_s = sync_q[2*NUM_CH+6];
    assign sda_s = sync_q[2*NUM_CH+7];
    assign scl_s = sync_q[2*NUM_CH+8];

    // bus line history for edge and framing detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_prev_r <= 1'b0;
            sda_prev_r <= 1'b0;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
        end
    end

    // start and stop are data edges while the clock line is high
    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign stop_det = scl_s && scl_prev_r && !sda_prev_r && sda_s;
    assign scl_rise = scl_s && !scl_prev_r;
    assign scl_fall = !scl_s && scl_prev_r;

    // serial slave: address, register pointer, then data with auto-increment
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= LBK_ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb_r <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (start_det) begin
                state_r <= LBK_ST_ADDR;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state_r <= LBK_ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    LBK_ST_ADDR, LBK_ST_REG, LBK_ST_WDATA: begin
                        shift_r <= {shift_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    LBK_ST_RACK: nack_r <= sda_s;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    LBK_ST_ADDR: begin
                        if (cnt_r == `LBK_BYTE_BITS) begin
                            // foreign addresses are left alone until the next start
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_r <= shift_r[0];
                                sda_oe <= 1'b1;
                                state_r <= LBK_ST_AACK;
                            end else begin
                                state_r <= LBK_ST_IDLE;
                            end
                        end
                    end
                    LBK_ST_AACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            shift_r <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            state_r <= LBK_ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state_r <= LBK_ST_REG;
                        end
                    end
                    LBK_ST_REG: begin
                        if (cnt_r == `LBK_BYTE_BITS) begin
                            ptr_r <= shift_r;
                            sda_oe <= 1'b1;
                            state_r <= LBK_ST_REG_ACK;
                        end
                    end
                    LBK_ST_REG_ACK: begin
                        sda_oe <= 1'b0;
                        cnt_r <= 4'h0;
                        state_r <= LBK_ST_WDATA;
                    end
                    LBK_ST_WDATA: begin
                        if (cnt_r == `LBK_BYTE_BITS) begin
                            wr_stb_r <= 1'b1;
                            sda_oe <= 1'b1;
                            state_r <= LBK_ST_WACK;
                        end
                    end
                    LBK_ST_WACK: begin
                        sda_oe <= 1'b0;
                        cnt_r <= 4'h0;
                        ptr_r <= ptr_r + 8'h01;
                        state_r <= LBK_ST_WDATA;
                    end
                    LBK_ST_RDATA: begin
                        if (cnt_r == `LBK_LAST_BIT) begin
                            sda_oe <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= LBK_ST_RACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe <= ~shift_r[6];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    LBK_ST_RACK: begin
                        // a missing acknowledge ends the read burst
                        if (nack_r) begin
                            state_r <= LBK_ST_IDLE;
                        end else begin
                            shift_r <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            cnt_r <= 4'h0;
                            state_r <= LBK_ST_RDATA;
                        end
                    end
                    default: state_r <= LBK_ST_IDLE;
                endcase
            end
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // write data and pointer hold still while the strobe is high
    assign wr_sel = reg_decode(ptr_r);
    assign rd_sel = reg_decode(ptr_r);

    lbk_los_latch #(
        .N(NUM_CH)
    ) u_latch_a (
        .clk(clk),
        .reset(reset),
        .live(live_s[0]),
        .clr_stb(wr_stb_r && (wr_sel == LBK_R_LOS_A)),
        .clr_data(shift_r[7:4]),
        .latched(latched[0])
    );

    lbk_los_latch #(
        .N(NUM_CH)
    ) u_latch_b (
        .clk(clk),
        .reset(reset),
        .live(live_s[1]),
        .clr_stb(wr_stb_r && (wr_sel == LBK_R_LOS_B)),
        .clr_data(shift_r[7:4]),
        .latched(latched[1])
    );

    // read multiplexer, unmapped addresses return zero
    always_comb begin
        case (rd_sel)
            LBK_R_LOOP: rd_byte = loop_r;
            LBK_R_LOS_A: rd_byte = {latched[0], live_s[0]};
            LBK_R_LOS_B: rd_byte = {latched[1], live_s[1]};
            LBK_R_CFG_A: rd_byte = cfg_r[0];
            LBK_R_LVL1_A: rd_byte = lvl1_r[0];
            LBK_R_LVL0_A: rd_byte = lvl0_r[0];
            LBK_R_CFG_B: rd_byte = cfg_r[1];
            LBK_R_LVL1_B: rd_byte = lvl1_r[1];
            LBK_R_LVL0_B: rd_byte = lvl0_r[1];
            default: rd_byte = `LBK_UNMAPPED;
        endcase
    end

    // loopback control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loop_r <= `LBK_LOOP_RST;
        end else if (wr_stb_r && (wr_sel == LBK_R_LOOP)) begin
            loop_r <= shift_r & `LBK_LOOP_MASK;
        end
    end

    // per-port transmit registers, one setting for all channels of a port
    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam lbk_reg_t CFG_ID = (p == 0) ? LBK_R_CFG_A : LBK_R_CFG_B;
        localparam lbk_reg_t LVL1_ID = (p == 0) ? LBK_R_LVL1_A : LBK_R_LVL1_B;
        localparam lbk_reg_t LVL0_ID = (p == 0) ? LBK_R_LVL0_A : LBK_R_LVL0_B;

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                cfg_r[p] <= `LBK_CFG_RST;
            end else if (wr_stb_r && (wr_sel == CFG_ID)) begin
                cfg_r[p] <= shift_r & `LBK_CFG_MASK;
            end
        end

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                pe_written_r[p] <= 1'b0;
            end else if (wr_stb_r && (wr_sel == CFG_ID)) begin
                pe_written_r[p] <= 1'b1;
            end
        end

        // level registers; level 1 stored as written, level 0 bit 7 cleared, host keeps combos legal
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                lvl1_r[p] <= `LBK_LVL_RST;
                lvl0_r[p] <= `LBK_LVL_RST;
            end else if (wr_stb_r) begin
                if (wr_sel == LVL1_ID) begin
                    lvl1_r[p] <= shift_r;
                end
                if (wr_sel == LVL0_ID) begin
                    lvl0_r[p] <= shift_r & {1'b0, 7'h7F};
                end
            end
        end

        // pins give even settings; one value per port
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                preemph_setting[p] <= 3'h0;
            end else if (pe_written_r[p]) begin
                preemph_setting[p] <= cfg_r[p][`LBK_CFG_PE_MSB:0];
            end else begin
                preemph_setting[p] <= {pe_pins_s[p], 1'b0};
            end
        end

        assign data_rate_high[p] = cfg_r[p][`LBK_CFG_RATE_BIT];
        assign out_enable[p] = cfg_r[p][`LBK_CFG_EN_BIT];
        assign preemph_source_select[p] = lvl1_r[p][`LBK_LVL_SRC_BIT];
        assign output_level_field_one[p] = lvl1_r[p][`LBK_LVL_MSB:0];
        assign output_level_field_zero[p] = lvl0_r[p][`LBK_LVL_MSB:0];
    end

    // pin modes 00 and 01, serial modes 10 and 11
    assign serial_mode = mode_s[1];
    // pin never reaches cable side; bit 0
    assign cable_nxt = serial_mode && loop_r[`LBK_LOOP_CABLE_BIT];
    // pin overrides bit 1 in pin mode
    assign board_nxt = serial_mode ? loop_r[`LBK_LOOP_BOARD_BIT] : toggle_s;

    // loopback outputs are registered so they never glitch on decode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cable_side_loop_en <= 1'b0;
            board_side_loop_en <= 1'b0;
            through_path_en <= 1'b1;
        end else begin
            cable_side_loop_en <= cable_nxt;
            board_side_loop_en <= board_nxt;
            // single loopback keeps traffic; full loopback stops it
            through_path_en <= !(cable_nxt && board_nxt);
        end
    end
endmodule // lbk_top
`default_nettype wire

// ---- test/lbk_assertions.sv ----
// concurrent checks on the bank's ports
`timescale 1ns/1ps
`default_nettype none
module lbk_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic loopback_toggle_pin,
    input wire logic [1:0] control_mode,
    input wire logic cable_side_loop_en,
    input wire logic board_side_loop_en,
    input wire logic through_path_en,
    input wire logic [1:0] data_rate_high,
    input wire logic [1:0] out_enable,
    input wire logic [1:0] preemph_source_select,
    input wire lbk_pkg::lbk_lvl_t [1:0] output_level_field_one,
    input wire lbk_pkg::lbk_lvl_t [1:0] output_level_field_zero
);
    import lbk_pkg::*;
    // eight cycles cover the synchroniser lag
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_full_stops_thru: assert property (
        through_path_en == !(cable_side_loop_en && board_side_loop_en))
        else $error("through path wrong");
    a_pin_no_cable: assert property (
        (!control_mode[1])[*8] |-> !cable_side_loop_en)
        else $error("cable loop in pin mode");
    a_pin_board_on: assert property (
        (!control_mode[1] && loopback_toggle_pin)[*8] |-> board_side_loop_en)
        else $error("pin high, no board loop");
    a_pin_board_off: assert property (
        (!control_mode[1] && !loopback_toggle_pin)[*8] |-> !board_side_loop_en)
        else $error("pin low, board loop on");
    a_tx_reset_vals: assert property (
        $fell(reset) |-> out_enable == 2'b11 && data_rate_high == 2'b00
        && preemph_source_select == 2'b00 && output_level_field_one == {7'h40, 7'h40}
        && output_level_field_zero == {7'h40, 7'h40})
        else $error("transmit reset values wrong");
    a_reg_update_low: assert property (
        $changed({data_rate_high, out_enable, preemph_source_select,
        output_level_field_one, output_level_field_zero}) |-> !scl_in)
        else $error("register changed, clock high");
    a_ack_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in && $past(!scl_in, 2))
        else $error("data moved, clock high");
    a_open_drain: assert property (
        sda_out == 1'b0)
        else $error("data pin driven high");
endmodule // lbk_assertions

bind lbk_top lbk_assertions u_chk (.clk(clk), .reset(reset), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .loopback_toggle_pin(loopback_toggle_pin),
    .control_mode(control_mode), .cable_side_loop_en(cable_side_loop_en),
    .board_side_loop_en(board_side_loop_en), .through_path_en(through_path_en),
    .data_rate_high(data_rate_high), .out_enable(out_enable),
    .preemph_source_select(preemph_source_select),
    .output_level_field_one(output_level_field_one),
    .output_level_field_zero(output_level_field_zero));
`default_nettype wire

// ---- test/lbk_host_model.sv ----
// serial bus host model
`timescale 1ns/1ps
`default_nettype none
module lbk_host_model #(
    // slave address value is arbitrary
    parameter logic [6:0] DEV = 7'h38
) (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_m,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    logic line;
    // pulled-up line
    assign line = sda_m & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    // half bit: ten clocks, over the filter lag
    task automatic ph();
        repeat (10) @(negedge clk);
    endtask
    task automatic start();
        sda_m = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_m = 1'b0;
        ph();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_m = 1'b1;
        ph();
    endtask
    // data set while clock low, ack read at end of ninth
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            ph();
            scl = 1'b1;
            ph();
            scl = 1'b0;
        end
        sda_m = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        ack = ~line;
        scl = 1'b0;
    endtask
    // one byte, ended by a nack
    task automatic rbyte(output logic [7:0] b);
        sda_m = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            ph();
            scl = 1'b1;
            ph();
            b[i] = line;
            scl = 1'b0;
        end
        ph();
        scl = 1'b1;
        ph();
        scl = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        wbyte({DEV, 1'b0}, k0);
        wbyte(a, k1);
        wbyte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // pointer write, repeated start, read
    task automatic rd(input logic [7:0] a);
        logic k;
        logic [7:0] b;
        start();
        wbyte({DEV, 1'b0}, k);
        wbyte(a, k);
        start();
        wbyte({DEV, 1'b1}, k);
        rbyte(b);
        stop();
        rd_data = b;
        rd_valid = 1'b1;
        @(negedge clk);
        rd_valid = 1'b0;
    endtask
endmodule // lbk_host_model
`default_nettype wire

// ---- test/test_loopback_los_tx_control.sv ----
// self-checking bench for the bank
`timescale 1ns/1ps
`default_nettype none
module test_loopback_los_tx_control;
    import lbk_pkg::*;
    // slave address value is arbitrary
    localparam logic [6:0] ADDR = 7'h38;
    logic clk, reset, scl, sda_m, sda_oe, sda_out, sda_line, rd_valid, pin, k;
    logic cable, board, thru;
    logic [3:0] los_a, los_b, r, r2;
    logic [1:0] pe_a, pe_b, mode, rate, oen, src;
    lbk_pe_t [1:0] pe;
    lbk_lvl_t [1:0] lv1, lv0;
    lbk_byte_t rd_data;
    lbk_byte_t exp_q[$];
    lbk_byte_t ra[10] = '{8'h02, 8'h1F, 8'h3F, 8'hC0, 8'hC1, 8'hC2, 8'hE0, 8'hE1, 8'hE2, 8'h10};
    lbk_byte_t rv[10] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h40, 8'h40, 8'h20, 8'h40, 8'h40, 8'h00};
    logic [15:0] seed = 16'hDC8D;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    assign sda_line = sda_m & ~sda_oe;
    lbk_top #(.NUM_CH(4), .DEV_ADDR(ADDR)) u_dut (.clk(clk), .reset(reset), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .los_live_a(los_a),
        .los_live_b(los_b), .loopback_toggle_pin(pin), .preemph_toggle_pins_a(pe_a),
        .preemph_toggle_pins_b(pe_b), .control_mode(mode), .cable_side_loop_en(cable),
        .board_side_loop_en(board), .through_path_en(thru), .preemph_setting(pe),
        .data_rate_high(rate), .out_enable(oen), .preemph_source_select(src),
        .output_level_field_one(lv1), .output_level_field_zero(lv0));
    lbk_host_model #(.DEV(ADDR)) u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl),
        .sda_m(sda_m), .rd_valid(rd_valid), .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input lbk_byte_t seen, input lbk_byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic lbk_byte_t rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    task automatic wclk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // each write fully acked
    task automatic wr(input lbk_byte_t a, input lbk_byte_t d);
        u_host.wr(a, d, k);
        chk1(k, 1'b1);
    endtask
    task automatic rd_exp(input lbk_byte_t a, input lbk_byte_t e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    // reads against oldest note
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            check(rd_data, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        {reset, pin, los_a, los_b, pe_a, pe_b, mode} = {1'b1, 1'b0, 12'h000, 2'b10};
        wclk(2);
        reset = 1'b0;
        wclk(8);
        for (int i = 0; i < 10; i++) begin
            rd_exp(ra[i], rv[i]);
        end
        // pins rule until a config write
        for (int p = 0; p < 4; p++) begin
            pe_b = 2'(p);
            pe_a = ~2'(p);
            wclk(10);
            check({5'h00, pe[1]}, {5'h00, 2'(p), 1'b0});
            check({5'h00, pe[0]}, {5'h00, ~2'(p), 1'b0});
        end
        mode = 2'h2 | 2'(rnd() >> 7);
        for (int v = 0; v < 4; v++) begin
            wr(8'h02, {rnd() & 8'hFC} | 8'(v));
            pin = 1'(rnd() >> 7);
            wclk(10);
            chk1(cable, v[0]);
            chk1(board, v[1]);
            chk1(thru, v != 3);
            rd_exp(8'h02, 8'(v));
        end
        mode = 2'(rnd() >> 7);
        for (int p = 0; p < 2; p++) begin
            pin = p[0];
            wclk(10);
            chk1(cable, 1'b0);
            chk1(board, p[0]);
            chk1(thru, 1'b1);
        end
        mode = 2'b11;
        pe_a = 2'(rnd() >> 6);
        wr(8'hC0, 8'hFF);
        rd_exp(8'hC0, 8'h37);
        check({5'h00, pe[0]}, 8'h07);
        chk1(rate[0], 1'b1);
        wr(8'hC0, 8'h05);
        wr(8'hE0, 8'h13);
        check({oen, rate, 1'b0, pe[0]}, 8'h25);
        check({oen[1], rate[1], 3'h0, pe[1]}, 8'h43);
        // supported level pairs only
        wr(8'hE1, 8'h91);
        wr(8'hE2, 8'h11);
        wr(8'hC1, 8'hA2);
        wr(8'hC2, 8'h22);
        check({src, lv1[1][5:0]}, 8'hD1);
        check({1'b0, lv0[1]}, 8'h11);
        rd_exp(8'hC1, 8'hA2);
        rd_exp(8'hE1, 8'h91);
        // latch, partial clear, set beats clear
        r = 4'(rnd()) | 4'h1;
        r2 = 4'(rnd()) | 4'h2;
        los_a = r;
        los_b = r2;
        wclk(10);
        los_a = 4'h0;
        wclk(10);
        rd_exp(8'h1F, {r, 4'h0});
        rd_exp(8'h3F, {r2, r2});
        wr(8'h1F, 8'hA0);
        rd_exp(8'h1F, {r & 4'hA, 4'h0});
        wr(8'h3F, 8'h00);
        rd_exp(8'h3F, {r2, r2});
        // foreign address
        u_host.start();
        u_host.wbyte({ADDR ^ 7'h01, 1'b0}, k);
        u_host.stop();
        chk1(k, 1'b0);
        wr(8'h02, 8'h03);
        reset = 1'b1;
        wclk(2);
        check({oen, src, cable, board, thru, 1'b0}, 8'hC2);
        check({1'b0, lv1[0]}, 8'h40);
        reset = 1'b0;
        wclk(8);
        rd_exp(8'h02, 8'h00);
        wclk(20);
        check(8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule // test_loopback_los_tx_control
`default_nettype wire
